// *** hw/pwr_pkg.sv ***
// ==========================================================================
// shared constants for the power-off / wake-up sequencer
// ==========================================================================
package pwr_pkg;
    // ======================================================================
    // clocks and timing
    // ======================================================================
    localparam int          CORE_CLK_HZ      = 20_000_000;  // core clock rate
    localparam int          XTAL_HZ_DEF      = 10_000_000;  // default crystal rate
    localparam int          RST_CNT_W        = 16;          // wake reset counter width
    localparam int          RST_XTAL_PERIODS = 65535;       // wake reset length in crystal periods
    localparam int          N_EXT_DEF        = 8;           // default count of external lines

    // ======================================================================
    // register map (byte addresses)
    // ======================================================================
    localparam int          ADDR_W        = 6;
    localparam logic [5:0]  OFS_CTRL      = 6'h00;
    localparam logic [5:0]  OFS_WAKE_EN   = 6'h04;
    localparam logic [5:0]  OFS_EXT_MASK  = 6'h08;
    localparam logic [5:0]  OFS_EXT_PEND  = 6'h0c;
    localparam logic [5:0]  OFS_SRC_PEND  = 6'h10;
    localparam logic [5:0]  OFS_INFO_A    = 6'h14;
    localparam logic [5:0]  OFS_INFO_B    = 6'h18;
    localparam logic [5:0]  OFS_GPIO_DIR  = 6'h1c;
    localparam logic [5:0]  OFS_GPIO_DATA = 6'h20;
    localparam logic [5:0]  OFS_STATUS    = 6'h24;
    localparam logic [5:0]  OFS_INT_STAT  = 6'h28;
    localparam logic [5:0]  OFS_INT_MASK  = 6'h2c;

    // ======================================================================
    // field positions
    // ======================================================================
    localparam int          CTRL_ENTER_BIT = 0;   // write 1: enter power-off
    localparam int          WAKE_RTC_BIT   = 31;  // rtc alarm wake enable
    localparam int          SRC_EXT_BIT    = 0;   // source pending: external group
    localparam int          SRC_RTC_BIT    = 1;   // source pending: rtc alarm
    localparam int          INT_WAKE_BIT   = 0;   // event: wake reset finished
    localparam int          INT_EXT_BIT    = 1;   // event: external pending set
    localparam int          INT_RTC_BIT    = 2;   // event: rtc alarm in run mode
    localparam int          INT_W          = 3;

    // ======================================================================
    // reset values
    // ======================================================================
    localparam logic [31:0] INFO_RST      = 32'h0000_0000;
    localparam logic [31:0] EXT_MASK_RST  = 32'hffff_ffff;
    localparam logic [31:0] ZERO_RST      = 32'h0000_0000;

    // ======================================================================
    // sequencer states
    // ======================================================================
    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_OFF  = 2'b01,
        ST_WAKE = 2'b10
    } pwr_state_e;
endpackage

// *** hw/wake_if.sv ***
`timescale 1ns/1ps
// ==========================================================================
// link between sequencer and wake reset counter
// ==========================================================================
interface wake_if;
    logic start;  // one-cycle pulse: begin reset stretch
    logic tick;   // one-cycle crystal period enable
    logic busy;   // stretch running
    logic done;   // one-cycle pulse: stretch finished

    modport ctl (output start, output tick, input busy, input done);
    modport cnt (input start, input tick, output busy, output done);
endinterface

// *** hw/reset_stretch.sv ***
`timescale 1ns/1ps
// ==========================================================================
// wake reset length counter, counts crystal periods
// ==========================================================================
module reset_stretch
    import pwr_pkg::*;
#(
    parameter int CNT_W = RST_CNT_W,
    parameter int LEN   = RST_XTAL_PERIODS
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    wake_if.cnt       w
);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(LEN - 1);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             busy_reg;
    logic             busy_next;
    logic             done_reg;
    logic             done_next;

    // next count: run from start until the last crystal period
    always_comb begin
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (w.start) begin
            cnt_next  = '0;
            busy_next = 1'b1;
        end else if (busy_reg && w.tick) begin
            if (cnt_reg == LAST) begin  // see R06
                busy_next = 1'b0;
                done_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    // count registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign w.busy = busy_reg;
    assign w.done = done_reg;
endmodule

// *** hw/power_off_wakeup_sequencer.sv ***
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
// ==========================================================================
// Summary of operation
// R01: software leaves wake source unmasked for pending
// R02: masked wake source wakes, sets no pending
// R03: both info words hold through power-off
// R04: software saves state into info words first
// R05: enabled wake event asserts internal reset
// R06: wake reset lasts 65535 crystal periods
// R07: gpio keeps driven level or input in power-off
// R08: software drives unloaded outputs high in power-off
// R09: rtc wake leaves rtc source pending clear
// R10: info words cleared only by pin or watchdog
// ==========================================================================
module power_off_wakeup_sequencer
    import pwr_pkg::*;
#(
    parameter int N_EXT            = N_EXT_DEF,
    parameter int N_GPIO           = 16,
    parameter int XTAL_HZ          = XTAL_HZ_DEF,
    parameter int RST_XTAL_PERIODS_P = RST_XTAL_PERIODS
) (
    input  wire logic              core_clk_i,
    input  wire logic              resetn_i,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o,
    // wake sources and watchdog reset
    input  wire logic [N_EXT-1:0]  ext_irq_i,
    input  wire logic              rtc_alarm_i,
    input  wire logic              watchdog_reset_i,
    // outputs
    output logic                   internal_reset_o,
    output logic                   power_off_o,
    output logic [N_GPIO-1:0]      gpio_out_o,
    output logic [N_GPIO-1:0]      gpio_oe_o,
    output logic                   irq_o
);
    // ======================================================================
    // derived timing
    // ======================================================================
    localparam int XTAL_DIV = (CORE_CLK_HZ + XTAL_HZ - 1) / XTAL_HZ;
    localparam int DIV_W    = (XTAL_DIV > 1) ? $clog2(XTAL_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(XTAL_DIV - 1);

    // byte-lane merge, used by every writable register except ctrl, which only checks byte lane 0
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ======================================================================
    // reset synchroniser
    // ======================================================================
    logic rst_meta_reg;
    logic rst_n;

    // two-flop release of the external reset pin
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // ======================================================================
    // crystal period divider and wake reset counter
    // ======================================================================
    wake_if wk();

    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] div_next;
    logic             tick_reg;
    logic             tick_next;
    logic             start_reg;
    logic             start_next;

    // divider giving one pulse per crystal period
    always_comb begin
        div_next  = (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
        tick_next = (div_reg == DIV_LAST);
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            div_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            div_reg  <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign wk.tick  = tick_reg;
    assign wk.start = start_reg;

    reset_stretch #(
        .CNT_W (RST_CNT_W),
        .LEN   (RST_XTAL_PERIODS_P)
    ) u_stretch (
        .clk_i   (core_clk_i),
        .rst_n_i (rst_n),
        .w       (wk.cnt)
    );

    // ======================================================================
    // register and sequencer state
    // ======================================================================
    pwr_state_e        state_reg, state_next;
    logic [31:0]       wake_en_reg, wake_en_next;
    logic [N_EXT-1:0]  ext_mask_reg, ext_mask_next;
    logic [N_EXT-1:0]  ext_pend_reg, ext_pend_next;
    logic [1:0]        src_pend_reg, src_pend_next;
    logic [31:0]       info_a_reg, info_a_next;
    logic [31:0]       info_b_reg, info_b_next;
    logic [N_GPIO-1:0] gpio_dir_reg, gpio_dir_next;
    logic [N_GPIO-1:0] gpio_data_reg, gpio_data_next;
    logic [INT_W-1:0]  int_stat_reg, int_stat_next;
    logic [INT_W-1:0]  int_mask_reg, int_mask_next;
    logic              ireset_reg, ireset_next;
    logic              irq_reg, irq_next;
    logic [31:0]       rdata_reg, rdata_next;
    logic              wait_reg, wait_next;
    logic              rtc_prev_reg;
    logic [N_EXT-1:0]  ext_prev_reg;

    logic              acc;
    logic              wr;
    logic [N_EXT-1:0]  ext_rise;
    logic              rtc_rise;
    logic              wake_evt;
    logic [N_EXT-1:0]  ext_set;
    logic              rtc_set;
    logic [31:0]       wd32;

    // ======================================================================
    // event decode
    // ======================================================================
    always_comb begin
        acc      = (avs_read_i || avs_write_i) && wait_reg;
        wr       = avs_write_i && wait_reg && (state_reg == ST_RUN);
        ext_rise = ext_irq_i & ~ext_prev_reg;
        rtc_rise = rtc_alarm_i && !rtc_prev_reg;
        // any enabled source wakes, mask or not
        wake_evt = (state_reg == ST_OFF) &&
                   ((|(ext_rise & wake_en_reg[N_EXT-1:0])) ||
                    (rtc_rise && wake_en_reg[WAKE_RTC_BIT]));  // see R02
        // pending only for unmasked lines
        ext_set  = ext_rise & ~ext_mask_reg;  // see R02
        // rtc pending never set by a wake from power-off
        rtc_set  = rtc_rise && (state_reg == ST_RUN);  // see R09
        wd32     = avs_writedata_i;
    end

    // ======================================================================
    // next state of sequencer, registers and bus
    // ======================================================================
    always_comb begin
        state_next     = state_reg;
        start_next     = 1'b0;
        ireset_next    = ireset_reg;
        wake_en_next   = wake_en_reg;
        ext_mask_next  = ext_mask_reg;
        ext_pend_next  = ext_pend_reg;
        src_pend_next  = src_pend_reg;
        info_a_next    = info_a_reg;   // see R03
        info_b_next    = info_b_reg;   // see R03
        gpio_dir_next  = gpio_dir_reg; // see R07
        gpio_data_next = gpio_data_reg;
        int_stat_next  = int_stat_reg;
        int_mask_next  = int_mask_reg;
        wait_next      = !acc;
        rdata_next     = rdata_reg;

        // software writes, run mode only; clears before sets
        if (wr) begin
            if (avs_address_i == OFS_CTRL) begin
                if (avs_byteenable_i[0] && wd32[CTRL_ENTER_BIT]) begin
                    state_next = ST_OFF;
                end
            end else if (avs_address_i == OFS_WAKE_EN) begin
                wake_en_next = merge(wake_en_reg, wd32, avs_byteenable_i);
            end else if (avs_address_i == OFS_EXT_MASK) begin
                ext_mask_next = N_EXT'(merge(32'(ext_mask_reg), wd32, avs_byteenable_i));
            end else if (avs_address_i == OFS_EXT_PEND) begin
                ext_pend_next = ext_pend_reg & ~N_EXT'(merge(ZERO_RST, wd32, avs_byteenable_i));
            end else if (avs_address_i == OFS_SRC_PEND) begin
                src_pend_next = src_pend_reg & ~2'(merge(ZERO_RST, wd32, avs_byteenable_i));
            end else if (avs_address_i == OFS_INFO_A) begin
                info_a_next = merge(info_a_reg, wd32, avs_byteenable_i);
            end else if (avs_address_i == OFS_INFO_B) begin
                info_b_next = merge(info_b_reg, wd32, avs_byteenable_i);
            end else if (avs_address_i == OFS_GPIO_DIR) begin
                gpio_dir_next = N_GPIO'(merge(32'(gpio_dir_reg), wd32, avs_byteenable_i));
            end else if (avs_address_i == OFS_GPIO_DATA) begin
                gpio_data_next = N_GPIO'(merge(32'(gpio_data_reg), wd32, avs_byteenable_i));
            end else if (avs_address_i == OFS_INT_STAT) begin
                int_stat_next = int_stat_reg & ~INT_W'(merge(ZERO_RST, wd32, avs_byteenable_i));
            end else if (avs_address_i == OFS_INT_MASK) begin
                int_mask_next = INT_W'(merge(32'(int_mask_reg), wd32, avs_byteenable_i));
            end
        end

        // hardware sets win over software clears
        ext_pend_next = ext_pend_next | ext_set;
        if (|ext_set) begin
            src_pend_next[SRC_EXT_BIT] = 1'b1;
            int_stat_next[INT_EXT_BIT] = 1'b1;
        end
        if (rtc_set) begin
            src_pend_next[SRC_RTC_BIT] = 1'b1;
            int_stat_next[INT_RTC_BIT] = 1'b1;
        end

        // sequencer
        case (state_reg)
            ST_OFF: begin
                if (wake_evt) begin
                    state_next  = ST_WAKE;
                    ireset_next = 1'b1;  // see R05
                    start_next  = 1'b1;
                end
            end
            ST_WAKE: begin
                if (wk.done) begin  // see R06
                    state_next                 = ST_RUN;
                    ireset_next                = 1'b0;
                    int_stat_next[INT_WAKE_BIT] = 1'b1;
                end
            end
            default: begin
                ireset_next = 1'b0;
            end
        endcase

        // watchdog clears the retained words
        if (watchdog_reset_i) begin
            info_a_next = INFO_RST;  // see R10
            info_b_next = INFO_RST;  // see R10
        end

        // read data, unmapped reads give zero
        if (acc && avs_read_i) begin
            if (avs_address_i == OFS_WAKE_EN) begin
                rdata_next = wake_en_reg;
            end else if (avs_address_i == OFS_EXT_MASK) begin
                rdata_next = 32'(ext_mask_reg);
            end else if (avs_address_i == OFS_EXT_PEND) begin
                rdata_next = 32'(ext_pend_reg);
            end else if (avs_address_i == OFS_SRC_PEND) begin
                rdata_next = 32'(src_pend_reg);
            end else if (avs_address_i == OFS_INFO_A) begin
                rdata_next = info_a_reg;
            end else if (avs_address_i == OFS_INFO_B) begin
                rdata_next = info_b_reg;
            end else if (avs_address_i == OFS_GPIO_DIR) begin
                rdata_next = 32'(gpio_dir_reg);
            end else if (avs_address_i == OFS_GPIO_DATA) begin
                rdata_next = 32'(gpio_data_reg);
            end else if (avs_address_i == OFS_STATUS) begin
                rdata_next = {29'h0, ireset_reg, 2'(state_reg)};
            end else if (avs_address_i == OFS_INT_STAT) begin
                rdata_next = 32'(int_stat_reg);
            end else if (avs_address_i == OFS_INT_MASK) begin
                rdata_next = 32'(int_mask_reg);
            end else begin
                rdata_next = ZERO_RST;
            end
        end

        irq_next = |(int_stat_next & int_mask_next);
    end

    // ======================================================================
    // registers
    // ======================================================================
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= ST_RUN;
            start_reg     <= 1'b0;
            ireset_reg    <= 1'b0;
            wake_en_reg   <= ZERO_RST;
            ext_mask_reg  <= EXT_MASK_RST[N_EXT-1:0];
            ext_pend_reg  <= '0;
            src_pend_reg  <= '0;
            info_a_reg    <= INFO_RST;  // see R10
            info_b_reg    <= INFO_RST;  // see R10
            gpio_dir_reg  <= '0;
            gpio_data_reg <= '0;
            int_stat_reg  <= '0;
            int_mask_reg  <= '0;
            irq_reg       <= 1'b0;
            rdata_reg     <= ZERO_RST;
            wait_reg      <= 1'b1;
            rtc_prev_reg  <= 1'b0;
            ext_prev_reg  <= '0;
        end else begin
            state_reg     <= state_next;
            start_reg     <= start_next;
            ireset_reg    <= ireset_next;
            wake_en_reg   <= wake_en_next;
            ext_mask_reg  <= ext_mask_next;
            ext_pend_reg  <= ext_pend_next;
            src_pend_reg  <= src_pend_next;
            info_a_reg    <= info_a_next;
            info_b_reg    <= info_b_next;
            gpio_dir_reg  <= gpio_dir_next;
            gpio_data_reg <= gpio_data_next;
            int_stat_reg  <= int_stat_next;
            int_mask_reg  <= int_mask_next;
            irq_reg       <= irq_next;
            rdata_reg     <= rdata_next;
            wait_reg      <= wait_next;
            rtc_prev_reg  <= rtc_alarm_i;
            ext_prev_reg  <= ext_irq_i;
        end
    end

    // ======================================================================
    // outputs, all straight from flops
    // ======================================================================
    assign avs_readdata_o    = rdata_reg;
    assign avs_waitrequest_o = wait_reg;
    assign internal_reset_o  = ireset_reg;
    assign power_off_o       = state_reg[0];
    assign gpio_out_o        = gpio_data_reg;  // see R07
    assign gpio_oe_o         = gpio_dir_reg;   // see R07
    assign irq_o             = irq_reg;
endmodule

// *** dv/wake_src_model.sv ***
`timescale 1ns/1ps
// ==========================================
// wake sources: external lines and rtc alarm
// ==========================================
module wake_src_model #(
    parameter int N_EXT = 8
) (
    input  wire logic             clk_i,
    output logic      [N_EXT-1:0] ext_irq_o,
    output logic                  rtc_alarm_o
);
    initial begin
        ext_irq_o   = '0;
        rtc_alarm_o = 1'b0;
    end
    // one rising edge on source k, held hold cycles
    task automatic fire(input int k, input int hold);
        @(posedge clk_i);
        if (k < N_EXT) ext_irq_o[k] <= 1'b1;
        else rtc_alarm_o <= 1'b1;
        repeat (hold) @(posedge clk_i);
        ext_irq_o   <= '0;
        rtc_alarm_o <= 1'b0;
    endtask
endmodule

// *** dv/power_off_wakeup_sequencer_monitor.sv ***
`timescale 1ns/1ps
// ==========================================
// port checker for the power-off sequencer
// ==========================================
module power_off_wakeup_sequencer_monitor #(
    parameter int P      = 8,
    parameter int N_GPIO = 16
) (
    input wire logic              core_clk_i,
    input wire logic              resetn_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic              avs_waitrequest_o,
    input wire logic              internal_reset_o,
    input wire logic              power_off_o,
    input wire logic [N_GPIO-1:0] gpio_out_o,
    input wire logic [N_GPIO-1:0] gpio_oe_o
);
    localparam int LO = 2 * P - 2;
    localparam int HI = 2 * P + 2;
    int cnt_reg;
    int cnt_next;
    // cycles spent in wake reset
    always_comb begin
        cnt_next = internal_reset_o ? cnt_reg + 1 : 0;
    end
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) cnt_reg <= 0;
        else cnt_reg <= cnt_next;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // ==========================================
    // assertions
    // ==========================================
    chk_exit_by_reset: assert property ($fell(power_off_o) |-> internal_reset_o)
        else $error("left power-off without wake reset");
    chk_wake_from_off: assert property ($rose(internal_reset_o) |-> $past(power_off_o))
        else $error("wake reset outside power-off");
    chk_reset_not_off: assert property (internal_reset_o |-> !power_off_o)
        else $error("power-off during wake reset");
    chk_reset_len_max: assert property (cnt_reg <= HI)
        else $error("wake reset too long");
    chk_reset_len_min: assert property ($fell(internal_reset_o) |-> cnt_reg >= LO)
        else $error("wake reset too short");
    chk_gpio_hold_off: assert property (power_off_o && $past(power_off_o) |-> $stable(gpio_out_o) && $stable(gpio_oe_o))
        else $error("gpio changed in power-off");
    chk_gpio_hold_wake: assert property (internal_reset_o && $past(internal_reset_o) |-> $stable(gpio_out_o))
        else $error("gpio changed in wake reset");
    chk_req_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered");
    chk_ack_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer held too long");
    cover property ($rose(power_off_o));
    cover property ($fell(internal_reset_o));
    cover property (avs_write_i && !avs_waitrequest_o);
endmodule
bind power_off_wakeup_sequencer power_off_wakeup_sequencer_monitor #(.P(RST_XTAL_PERIODS_P), .N_GPIO(N_GPIO)) u_mon (
    .core_clk_i, .resetn_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
    .internal_reset_o, .power_off_o, .gpio_out_o, .gpio_oe_o);

// *** dv/power_off_wakeup_sequencer_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module power_off_wakeup_sequencer_tb
    import pwr_pkg::*;
;
    logic        core_clk_i = 1'b0;
    logic        resetn_i   = 1'b0;
    logic [5:0]  address    = '0;
    logic        rd_req     = 1'b0;
    logic        wr_req     = 1'b0;
    logic        wdog       = 1'b0;
    logic [31:0] wdata      = '0;
    logic [31:0] rdata, info_a, info_b, e_q;
    logic        wait_req, irq, ireset, poff, rtc;
    logic [15:0] gout, goe, dir;
    logic [7:0]  ext;
    logic [31:0] exp_q[$];
    int          src[3]     = '{3, 0, 8};
    int          num_errors = 0;
    int          num_checks = 0;
    int          seed       = 32'h62c155f0;
    always #25 core_clk_i = ~core_clk_i;
    power_off_wakeup_sequencer #(.RST_XTAL_PERIODS_P(8)) u_power_off_wakeup_sequencer (
        .core_clk_i, .resetn_i, .avs_address_i(address), .avs_read_i(rd_req), .avs_write_i(wr_req),
        .avs_writedata_i(wdata), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_req), .ext_irq_i(ext), .rtc_alarm_i(rtc), .watchdog_reset_i(wdog),
        .internal_reset_o(ireset), .power_off_o(poff), .gpio_out_o(gout), .gpio_oe_o(goe), .irq_o(irq));
    wake_src_model u_wake_src_model (.clk_i(core_clk_i), .ext_irq_o(ext), .rtc_alarm_o(rtc));
    // read results checked in arrival order
    always @(posedge core_clk_i) begin
        if (rd_req && wait_req === 1'b0) begin
            e_q = exp_q.pop_front();
            `CHK(rdata, e_q)
        end
    end
    // one avalon access, held until waitrequest low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge core_clk_i);
        address <= a;
        wdata   <= d;
        wr_req  <= w;
        rd_req  <= !w;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        if (n == 50) num_errors++;
        wr_req <= 1'b0;
        rd_req <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        bus(1'b0, a, '0);
    endtask
    task automatic wait_ireset(input logic v);
        int n;
        for (n = 0; n < 100 && ireset !== v; n++)
            @(posedge core_clk_i);
        if (n == 100) num_errors++;
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        info_a = $random(seed);
        info_b = $random(seed);
        dir    = $random(seed);
        repeat (4) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        rd(OFS_EXT_MASK, EXT_MASK_RST & 32'hff);
        rd(OFS_INFO_A, INFO_RST);
        rd(6'h30, ZERO_RST);
        rd(OFS_CTRL, ZERO_RST);
        $display("test reset_values done");
        bus(1'b1, OFS_INFO_A, info_a);
        bus(1'b1, OFS_INFO_B, info_b);
        bus(1'b1, OFS_GPIO_DIR, {16'h0, dir});
        bus(1'b1, OFS_GPIO_DATA, 32'h0000ffff);
        bus(1'b1, OFS_WAKE_EN, 32'h800000ff);
        bus(1'b1, OFS_EXT_MASK, 32'hfffffffe);
        bus(1'b1, OFS_INT_MASK, 32'h1);
        // masked line, unmasked line, rtc alarm
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, OFS_CTRL, 32'h1);
            `CHK(poff, 1'b1)
            `CHK(gout, 16'hffff)
            `CHK(goe, dir)
            bus(1'b1, OFS_INFO_A, ~info_a);
            bus(1'b1, OFS_GPIO_DATA, 32'h0);
            u_wake_src_model.fire(src[k], k + 1);
            wait_ireset(1'b1);
            `CHK(poff, 1'b0)
            wait_ireset(1'b0);
            repeat (2) @(posedge core_clk_i);
            `CHK(irq, 1'b1)
            rd(OFS_EXT_PEND, {31'h0, k == 1});
            rd(OFS_SRC_PEND, {31'h0, k == 1});
            rd(OFS_INT_STAT, k == 1 ? 32'h3 : 32'h1);
            rd(OFS_INFO_A, info_a);
            rd(OFS_INFO_B, info_b);
            rd(OFS_GPIO_DATA, 32'h0000ffff);
            bus(1'b1, OFS_INT_STAT, 32'h1);
            repeat (2) @(posedge core_clk_i);
            `CHK(irq, 1'b0)
            bus(1'b1, OFS_INT_STAT, 32'h7);
            bus(1'b1, OFS_EXT_PEND, 32'hff);
            bus(1'b1, OFS_SRC_PEND, 32'h3);
            $display("test wake %0d done", k);
        end
        // rtc alarm in run mode, then unmask it
        u_wake_src_model.fire(8, 2);
        rd(OFS_SRC_PEND, 32'h2);
        rd(OFS_INT_STAT, 32'h4);
        bus(1'b1, OFS_INT_MASK, 32'h4);
        repeat (2) @(posedge core_clk_i);
        `CHK(irq, 1'b1)
        $display("test rtc_run done");
        // watchdog clears the info words
        wdog <= 1'b1;
        @(posedge core_clk_i);
        wdog <= 1'b0;
        rd(OFS_INFO_A, INFO_RST);
        rd(OFS_INFO_B, INFO_RST);
        $display("test watchdog done");
        finish_test();
    end
    // cut a hung run short
    initial begin
        #1000000;
        num_errors++;
        finish_test();
    end
endmodule
